/* vdfc_params.svh */
// Constants for the video decoder front control register bank.
// Assumes inclusion by the package and both bus ends; definitions only.
`ifndef VDFC_PARAMS_SVH
`define VDFC_PARAMS_SVH

// Subaddresses
`define VDFC_SUB_AIC2 8'h03
`define VDFC_SUB_GAIN1 8'h04
`define VDFC_SUB_GAIN2 8'h05
`define VDFC_SUB_HS_BEGIN 8'h06
`define VDFC_SUB_HS_END 8'h07
`define VDFC_SUB_SYNC 8'h08
`define VDFC_SUB_LUMA 8'h09
`define VDFC_SUB_BRIGHT 8'h0a
`define VDFC_SUB_FIRST 8'h03
`define VDFC_SUB_LAST 8'h0a
`define VDFC_NUM_REGS 8

// Field positions in analog_input_control_2
`define VDFC_B_URS 6
`define VDFC_B_LVB 5
`define VDFC_B_WPD 4
`define VDFC_B_GFRZ 3
`define VDFC_B_FGS 2
`define VDFC_B_G2MSB 1
`define VDFC_B_G1MSB 0
`define VDFC_AIC2_MASK 8'h7f

// Field positions in sync_field_control
`define VDFC_B_AUTO_FIELD_DETECT 7
`define VDFC_B_FIELD_RATE_SELECT 6
`define VDFC_B_FORCED_FIELD_TOGGLE 5
`define VDFC_B_HORIZ_PLL_OPEN 2
`define VDFC_HTC_TV 2'h0
`define VDFC_HTC_VTR 2'h1
`define VDFC_HTC_RSVD 2'h2
`define VDFC_HTC_FAST 2'h3
`define VDFC_VN_FAST 2'h1

// Field positions in luma_filter_control
`define VDFC_B_CHROMA_TRAP_BYPASS 7
`define VDFC_B_ADAPTIVE_LUMA_COMB 6
`define VDFC_B_ADDED_LINE_DELAY 5
`define VDFC_B_REMOD_BANDWIDTH_SELECT 4

// Sync delay limits, first active lines, source modes
`define VDFC_HS_LIM_50 8'sd108
`define VDFC_HS_LIM_60 8'sd107
`define VDFC_ACTIVE_LINE_60 10'd22
`define VDFC_ACTIVE_LINE_50 10'd24
`define VDFC_MODE_YC_FIRST 4'h6
`define VDFC_MODE_YC_LAST 4'h9
`define VDFC_MODE_YC_STATIC_LAST 4'h7

// Serial bus
`define VDFC_DEV_ADDR 7'h21
`define VDFC_REG_RESET 8'h00
`define VDFC_CLK_MHZ 25
`define VDFC_QTR_NS 2500
`define VDFC_QTR_CYC ((`VDFC_QTR_NS * `VDFC_CLK_MHZ + 999) / 1000)

`endif

/* vdfc_pkg.sv */
// Types shared by both ends of the decoder front control link.
// Assumes vdfc_params.svh is on the include path.
package vdfc_pkg;
  `include "vdfc_params.svh"

  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_SUB, DS_WDATA, DS_RDATA} vdfc_dev_st_e;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} vdfc_host_st_e;
  typedef enum logic [1:0] {FLT_TRAP, FLT_COMB, FLT_BYPASS} vdfc_filter_e;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    vdfc_dev_st_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] sub;
    logic pull;
    logic [`VDFC_NUM_REGS-1:0][7:0] regs;
  } vdfc_dev_s;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    vdfc_host_st_e st;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [2:0] idx;
    logic [7:0] shreg;
    logic [7:0] rx;
    logic [7:0] sub;
    logic [7:0] wdata;
    logic rd;
    logic scl;
    logic pull;
    logic nack;
    logic done;
    logic refused;
    logic [7:0] rdata;
  } vdfc_host_s;

  // Sync delay code inside the central counter range for the field rate
  function automatic logic vdfc_hs_ok(input logic [7:0] code, input logic is60);
    logic signed [7:0] s;
    logic signed [7:0] lim;
    s = $signed(code);
    lim = is60 ? `VDFC_HS_LIM_60 : `VDFC_HS_LIM_50;
    return (s >= -lim) && (s <= lim);
  endfunction : vdfc_hs_ok
endpackage : vdfc_pkg

/* vdfc_if.sv */
// Two-wire serial control link between host and decoder front control.
// Both ends pull the data line low only; the line idles high.
`timescale 1ns/1ps
`default_nettype none
interface vdfc_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Wired-AND of both open-drain drivers with a pull-up
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : vdfc_if
`default_nettype wire

/* vdfc_dev_regs.sv */
// Decoder front control register bank, subaddresses 03h to 0ah, serial slave.
// Assumes the decoder status inputs come from logic on i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "vdfc_params.svh"

// Notes on behaviour
// (R01) Unlocked: bit selects clamp reference
// (R02) Long blanking extends gain hold to active
// (R03) White peak limiter off when bit set
// (R04) Gain freeze holds integrated gain value
// (R05) Fixed gain uses both static gains
// (R06) Channel 1 gain: 03h bit0 plus 04h
// (R07) Channel 2 gain: 03h bit1 plus 05h
// (R08) Host avoids reference select with limiter on
// (R09) Sync begin: signed, steps of eight clocks
// (R10) Sync end: same encoding and range
// (R11) Field rate automatic or forced by select
// (R12) Forced toggle flips field every field
// (R13) Horizontal time constant: TV, VTR, fast
// (R14) PLL open holds horizontal frequency
// (R15) Vertical noise mode; fast needs manual field
// (R16) Bypass bit disables trap or comb
// (R17) Comb bit chooses comb over trap
// (R18) Extra line delay outside comb mode
// (R19) Remodulation bandwidth selects notch width
// (R20) Sharpness: plain, peaking, low-pass
// (R21) Brightness unsigned offset, 128 nominal
// (R22) Host bypasses trap for Y/C modes
// (R23) Input mode: composite, Y/C, reserved
// (R24) Host writes zero to reserved bits
module vdfc_dev_regs #(
  parameter logic [6:0] DEV_ADDR = `VDFC_DEV_ADDR
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Serial link
  vdfc_if.device bus,
  // Decoder status
  input wire logic i_decoder_locked,
  input wire logic i_detected_60hz,
  input wire logic i_pal_standard,
  input wire logic [3:0] i_input_mode,
  input wire logic i_in_eq_serration,
  input wire logic i_after_pre_eq,
  input wire logic [9:0] i_line_number,
  // Analog front end control
  output logic o_clamp_ref_select,
  output logic o_gain_suspend,
  output logic o_white_peak_enable,
  output logic o_gain_freeze,
  output logic o_gain_fixed,
  output logic o_ch2_static_gain,
  output logic [8:0] o_gain1_code,
  output logic [8:0] o_gain2_code,
  output logic o_source_yc,
  output logic o_mode_reserved,
  // Sync control
  output logic signed [10:0] o_hsync_begin_llc,
  output logic signed [10:0] o_hsync_end_llc,
  output logic o_hsync_range_err,
  output logic o_field_60hz,
  output logic o_field_toggle_forced,
  output logic [1:0] o_horiz_time_constant,
  output logic o_htc_reserved,
  output logic o_horiz_pll_open,
  output logic [1:0] o_vertical_noise_mode,
  // Luma control
  output vdfc_pkg::vdfc_filter_e o_luma_filter,
  output logic [1:0] o_added_lines,
  output logic o_wide_notch,
  output logic [3:0] o_sharpness_filter_select,
  output logic o_peaking_active,
  output logic o_lowpass_active,
  output logic [7:0] o_brightness_offset
);
  import vdfc_pkg::*;

  vdfc_dev_s q;
  vdfc_dev_s d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] aic2;
  logic [7:0] sync;
  logic [7:0] luma;

  function automatic logic in_map(input logic [7:0] sub);
    return (sub >= `VDFC_SUB_FIRST) && (sub <= `VDFC_SUB_LAST);
  endfunction : in_map

  function automatic logic [2:0] reg_idx(input logic [7:0] sub);
    logic [7:0] off;
    off = sub - `VDFC_SUB_FIRST;
    return off[2:0];
  endfunction : reg_idx

  // Unmapped subaddresses read as zero
  function automatic logic [7:0] rd_reg(input vdfc_dev_s s, input logic [7:0] sub);
    return in_map(sub) ? s.regs[reg_idx(sub)] : 8'h00;
  endfunction : rd_reg

  function automatic logic [7:0] reg_at(input vdfc_dev_s s, input logic [7:0] sub);
    return s.regs[reg_idx(sub)];
  endfunction : reg_at

  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign bus_start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign bus_stop = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

  always_comb
  begin
    d = q;
    d.scl_s1 = bus.scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    if (bus_start)
    begin
      d.st = DS_ADDR;
      d.bitcnt = 4'h0;
      d.pull = 1'b0;
    end
    else if (bus_stop)
    begin
      d.st = DS_IDLE;
      d.pull = 1'b0;
    end
    else if (q.st != DS_IDLE)
    begin
      if (scl_rise)
      begin
        if (q.bitcnt < 4'h8)
        begin
          d.shreg = {q.shreg[6:0], q.sda_s2};
          d.bitcnt = q.bitcnt + 4'h1;
        end
        else
        begin
          d.bitcnt = 4'h9;
          // Host answers the last read byte with a release: end of read
          if (q.st == DS_RDATA && q.sda_s2)
            d.st = DS_IDLE;
        end
      end
      else if (scl_fall)
      begin
        if (q.bitcnt == 4'h8)
        begin
          d.pull = 1'b0;
          case (q.st)
            DS_ADDR:
              if (q.shreg[7:1] == DEV_ADDR)
              begin
                d.pull = 1'b1;
                if (q.shreg[0])
                begin
                  d.st = DS_RDATA;
                  d.shreg = rd_reg(q, q.sub);
                end
                else
                  d.st = DS_SUB;
              end
              else
                d.st = DS_IDLE;
            DS_SUB:
            begin
              d.sub = q.shreg;
              d.pull = 1'b1;
              d.st = DS_WDATA;
            end
            DS_WDATA:
            begin
              // Unmapped writes are acknowledged and dropped
              if (in_map(q.sub))
                d.regs[reg_idx(q.sub)] = (q.sub == `VDFC_SUB_AIC2) ?
                  (q.shreg & `VDFC_AIC2_MASK) : q.shreg;
              d.sub = q.sub + 8'h01;
              d.pull = 1'b1;
            end
            DS_RDATA:
            begin
              d.sub = q.sub + 8'h01;
              d.shreg = rd_reg(q, q.sub + 8'h01);
            end
            default:
              d.pull = 1'b0;
          endcase
        end
        else
        begin
          if (q.bitcnt == 4'h9)
            d.bitcnt = 4'h0;
          d.pull = (q.st == DS_RDATA) & ~q.shreg[7];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= DS_IDLE;
      q.regs <= {`VDFC_NUM_REGS{`VDFC_REG_RESET}};
    end
    else
      q <= d;
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = ~q.pull;

  assign aic2 = reg_at(q, `VDFC_SUB_AIC2);
  assign sync = reg_at(q, `VDFC_SUB_SYNC);
  assign luma = reg_at(q, `VDFC_SUB_LUMA);

  // Analog front end
  assign o_clamp_ref_select = aic2[`VDFC_B_URS] & ~i_decoder_locked; // (R01)
  assign o_gain_suspend = aic2[`VDFC_B_LVB] ?
    (i_after_pre_eq && (i_line_number < (o_field_60hz ? `VDFC_ACTIVE_LINE_60 :
    `VDFC_ACTIVE_LINE_50))) : i_in_eq_serration; // (R02)
  assign o_white_peak_enable = ~aic2[`VDFC_B_WPD]; // (R03)
  assign o_gain_freeze = aic2[`VDFC_B_GFRZ]; // (R04)
  assign o_gain_fixed = aic2[`VDFC_B_FGS]; // (R05)
  // In Y/C modes 6 and 7 channel 2 takes the static gain even under auto
  assign o_ch2_static_gain = aic2[`VDFC_B_FGS] | (o_source_yc &&
    i_input_mode <= `VDFC_MODE_YC_STATIC_LAST); // (R05)
  assign o_gain1_code = {aic2[`VDFC_B_G1MSB], reg_at(q, `VDFC_SUB_GAIN1)}; // (R06)
  assign o_gain2_code = {aic2[`VDFC_B_G2MSB], reg_at(q, `VDFC_SUB_GAIN2)}; // (R07)
  assign o_source_yc = (i_input_mode >= `VDFC_MODE_YC_FIRST) &&
    (i_input_mode <= `VDFC_MODE_YC_LAST); // (R23)
  assign o_mode_reserved = i_input_mode > `VDFC_MODE_YC_LAST; // (R23)

  // Sync; a forbidden delay code is flagged, not corrected
  assign o_hsync_begin_llc = $signed({reg_at(q, `VDFC_SUB_HS_BEGIN), 3'b000}); // (R09)
  assign o_hsync_end_llc = $signed({reg_at(q, `VDFC_SUB_HS_END), 3'b000}); // (R10)
  assign o_hsync_range_err = ~vdfc_hs_ok(reg_at(q, `VDFC_SUB_HS_BEGIN), o_field_60hz) |
    ~vdfc_hs_ok(reg_at(q, `VDFC_SUB_HS_END), o_field_60hz); // (R09) (R10)
  assign o_field_60hz = sync[`VDFC_B_AUTO_FIELD_DETECT] ? i_detected_60hz : sync[`VDFC_B_FIELD_RATE_SELECT]; // (R11)
  assign o_field_toggle_forced = sync[`VDFC_B_FORCED_FIELD_TOGGLE]; // (R12)
  assign o_horiz_time_constant = sync[4:3]; // (R13)
  assign o_htc_reserved = sync[4:3] == `VDFC_HTC_RSVD; // (R13)
  assign o_horiz_pll_open = sync[`VDFC_B_HORIZ_PLL_OPEN]; // (R14)
  assign o_vertical_noise_mode = sync[1:0]; // (R15)

  // Luma
  assign o_luma_filter = luma[`VDFC_B_CHROMA_TRAP_BYPASS] ? FLT_BYPASS :
    (luma[`VDFC_B_ADAPTIVE_LUMA_COMB] ? FLT_COMB : FLT_TRAP); // (R16) (R17)
  assign o_added_lines = (luma[`VDFC_B_ADDED_LINE_DELAY] && o_luma_filter != FLT_COMB) ?
    (i_pal_standard ? 2'd2 : 2'd1) : 2'd0; // (R18)
  assign o_wide_notch = luma[`VDFC_B_REMOD_BANDWIDTH_SELECT]; // (R19)
  assign o_sharpness_filter_select = luma[3:0]; // (R20)
  assign o_peaking_active = (luma[3:0] != 4'h0) && !luma[3]; // (R20)
  assign o_lowpass_active = luma[3]; // (R20)
  assign o_brightness_offset = reg_at(q, `VDFC_SUB_BRIGHT); // (R21)
endmodule : vdfc_dev_regs
`default_nettype wire

/* vdfc_host_ctrl.sv */
// Host end: single-register write or read over the two-wire control link.
// Assumes one request at a time, taken only while o_busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "vdfc_params.svh"
module vdfc_host_ctrl #(
  parameter logic [6:0] DEV_ADDR = `VDFC_DEV_ADDR,
  parameter int QTR_CYC = `VDFC_QTR_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // User request
  input wire logic i_req,
  input wire logic i_rd,
  input wire logic [7:0] i_sub,
  input wire logic [7:0] i_wdata,
  input wire logic i_rate_60hz,
  input wire logic i_yc_mode,
  // User answer
  output logic o_busy,
  output logic o_done,
  output logic o_refused,
  output logic o_nack,
  output logic [7:0] o_rdata,
  // Serial link
  vdfc_if.host bus
);
  import vdfc_pkg::*;

  vdfc_host_s q;
  vdfc_host_s d;
  logic tick;

  // Writes that would break restriction R08, R09, R10 or R15 are refused outright
  function automatic logic wr_ok(input logic [7:0] sub, input logic [7:0] v,
                                 input logic is60);
    if (sub == `VDFC_SUB_AIC2)
      return !(v[`VDFC_B_URS] && !v[`VDFC_B_WPD]); // (R08)
    else if (sub == `VDFC_SUB_HS_BEGIN || sub == `VDFC_SUB_HS_END)
      return vdfc_hs_ok(v, is60); // (R09) (R10)
    else if (sub == `VDFC_SUB_SYNC)
      return !(v[1:0] == `VDFC_VN_FAST && v[`VDFC_B_AUTO_FIELD_DETECT]); // (R15)
    else
      return 1'b1;
  endfunction : wr_ok

  function automatic logic [7:0] wr_fix(input logic [7:0] sub, input logic [7:0] v,
                                        input logic yc);
    if (sub == `VDFC_SUB_AIC2)
      return v & `VDFC_AIC2_MASK; // (R24)
    else if (sub == `VDFC_SUB_LUMA && yc)
      return v | 8'h80; // (R22)
    else
      return v;
  endfunction : wr_fix

  function automatic logic [7:0] byte_for(input vdfc_host_s s);
    case (s.idx)
      3'd0: return {DEV_ADDR, 1'b0};
      3'd1: return s.sub;
      3'd2: return s.wdata;
      3'd3: return {DEV_ADDR, 1'b1};
      default: return 8'hff;
    endcase
  endfunction : byte_for

  assign tick = q.qcnt == 8'(QTR_CYC - 1);

  always_comb
  begin
    d = q;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.done = 1'b0;
    d.refused = 1'b0;
    d.qcnt = tick ? 8'h00 : q.qcnt + 8'h01;
    if (tick)
      d.phase = q.phase + 2'd1;
    case (q.st)
      HS_IDLE:
      begin
        d.scl = 1'b1;
        d.pull = 1'b0;
        d.qcnt = 8'h00;
        d.phase = 2'd0;
        if (i_req)
        begin
          if (!i_rd && !wr_ok(i_sub, i_wdata, i_rate_60hz))
            d.refused = 1'b1;
          else
          begin
            d.st = HS_START;
            d.rd = i_rd;
            d.sub = i_sub;
            d.wdata = wr_fix(i_sub, i_wdata, i_yc_mode);
            d.idx = 3'd0;
            d.nack = 1'b0;
          end
        end
      end
      HS_START:
      begin
        d.scl = q.phase == 2'd1 || q.phase == 2'd2;
        d.pull = q.phase >= 2'd2;
        if (tick && q.phase == 2'd3)
        begin
          d.st = HS_BIT;
          d.bitn = 4'h0;
          d.shreg = byte_for(q);
        end
      end
      HS_BIT:
      begin
        d.scl = q.phase == 2'd1 || q.phase == 2'd2;
        d.pull = (q.idx != 3'd4) && (q.bitn < 4'h8) && !q.shreg[7];
        if (tick && q.phase == 2'd2)
        begin
          if (q.bitn < 4'h8)
            d.rx = {q.rx[6:0], q.sda_s2};
          else if (q.idx != 3'd4 && q.sda_s2)
            d.nack = 1'b1;
        end
        if (tick && q.phase == 2'd3)
        begin
          if (q.bitn < 4'h8)
          begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.bitn = q.bitn + 4'h1;
          end
          else if (q.nack || q.idx == 3'd2 || q.idx == 3'd4)
            d.st = HS_STOP;
          else if (q.idx == 3'd1 && q.rd)
          begin
            d.idx = 3'd3;
            d.st = HS_START;
          end
          else
          begin
            d.idx = q.idx + 3'd1;
            d.bitn = 4'h0;
            d.shreg = byte_for(d);
          end
        end
      end
      default:
      begin
        d.scl = q.phase != 2'd0;
        d.pull = q.phase < 2'd2;
        if (tick && q.phase == 2'd3)
        begin
          d.st = HS_IDLE;
          d.done = 1'b1;
          if (q.rd && !q.nack)
            d.rdata = q.rx;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q <= '0;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.scl <= 1'b1;
      q.st <= HS_IDLE;
    end
    else
      q <= d;
  end

  assign bus.scl = q.scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = ~q.pull;
  assign o_busy = q.st != HS_IDLE;
  assign o_done = q.done;
  assign o_refused = q.refused;
  assign o_nack = q.nack;
  assign o_rdata = q.rdata;
endmodule : vdfc_host_ctrl
`default_nettype wire

/* vdfc_assertions.sv */
// Checker for the decoder front control link and its decoded outputs.
// Assumes instantiation beside the link interface in the bench, one clock.
`timescale 1ns/1ps
`default_nettype none
module vdfc_assertions (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Link and host answer
  input wire logic scl,
  input wire logic o_refused,
  input wire logic o_done,
  // Decoder status
  input wire logic i_decoder_locked,
  input wire logic i_pal_standard,
  input wire logic [3:0] i_input_mode,
  // Decoded controls
  input wire logic o_clamp_ref_select,
  input wire logic o_white_peak_enable,
  input wire logic o_gain_fixed,
  input wire logic o_ch2_static_gain,
  input wire logic o_source_yc,
  input wire logic o_mode_reserved,
  input wire logic signed [10:0] o_hsync_begin_llc,
  input wire logic signed [10:0] o_hsync_end_llc,
  input wire logic [1:0] o_horiz_time_constant,
  input wire logic o_htc_reserved,
  input wire vdfc_pkg::vdfc_filter_e o_luma_filter,
  input wire logic [1:0] o_added_lines,
  input wire logic [3:0] o_sharpness_filter_select,
  input wire logic o_peaking_active,
  input wire logic o_lowpass_active,
  input wire logic [7:0] o_brightness_offset
);
  import vdfc_pkg::*;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  // The brightness register only moves as part of a write that then completes
  sequence bright_moves;
    $changed(o_brightness_offset);
  endsequence
  sequence write_ends;
    ##[1:160] o_done;
  endsequence

  clamp_when_unlocked_a: assert property (o_clamp_ref_select |-> !i_decoder_locked)
    else $error("clamp reference select while locked");
  limiter_ref_a: assert property (o_clamp_ref_select |-> !o_white_peak_enable)
    else $error("reference select with limiter on");
  fixed_both_a: assert property (o_ch2_static_gain == (o_gain_fixed
    || i_input_mode inside {[4'h6:4'h7]}))
    else $error("fixed gain without static channel 2");
  hs_begin_step_a: assert property (o_hsync_begin_llc[2:0] == 3'h0)
    else $error("sync begin not in steps of eight");
  hs_end_step_a: assert property (o_hsync_end_llc[2:0] == 3'h0)
    else $error("sync end not in steps of eight");
  htc_reserved_a: assert property (o_htc_reserved == (o_horiz_time_constant == 2'h2))
    else $error("time constant reserved flag wrong");
  sharp_class_a: assert property (o_lowpass_active == o_sharpness_filter_select[3]
    && o_peaking_active == (o_sharpness_filter_select inside {[4'h1:4'h7]}))
    else $error("sharpness class wrong");
  line_delay_a: assert property (o_added_lines != 2'h0 |-> o_luma_filter != FLT_COMB
    && o_added_lines == (i_pal_standard ? 2'h2 : 2'h1))
    else $error("added line delay wrong");
  mode_class_a: assert property (o_source_yc == (i_input_mode inside {[4'h6:4'h9]})
    && o_mode_reserved == (i_input_mode > 4'h9))
    else $error("input mode class wrong");
  bright_write_a: assert property (bright_moves |-> write_ends)
    else $error("brightness moved outside a write");
  refuse_quiet_a: assert property (o_refused |-> scl [*2])
    else $error("refused request reached the link");
endmodule : vdfc_assertions
`default_nettype wire

/* video_decoder_front_control_regs_bench.sv */
// Bench joining host end and register bank through the link interface.
// Assumes the design files and vdfc_assertions are compiled first.
`timescale 1ns/1ps
`default_nettype none
module video_decoder_front_control_regs_bench;
  import vdfc_pkg::*;
  logic i_ref_clk, i_reset, i_req, i_rd, i_rate_60hz, i_yc_mode;
  logic [7:0] i_sub, i_wdata, o_rdata, o_brightness_offset;
  logic o_busy, o_done, o_refused, o_nack;
  logic i_decoder_locked, i_detected_60hz, i_pal_standard, i_in_eq_serration, i_after_pre_eq;
  logic [3:0] i_input_mode, o_sharpness_filter_select;
  logic [9:0] i_line_number;
  logic o_clamp_ref_select, o_gain_suspend, o_white_peak_enable, o_gain_freeze, o_gain_fixed;
  logic o_ch2_static_gain, o_source_yc, o_mode_reserved, o_hsync_range_err, o_field_60hz;
  logic o_field_toggle_forced, o_htc_reserved, o_horiz_pll_open, o_wide_notch;
  logic o_peaking_active, o_lowpass_active;
  logic [8:0] o_gain1_code, o_gain2_code;
  logic signed [10:0] o_hsync_begin_llc, o_hsync_end_llc;
  logic [1:0] o_horiz_time_constant, o_vertical_noise_mode, o_added_lines;
  vdfc_filter_e o_luma_filter;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  vdfc_if lnk ();
  // Short quarter-bit time keeps the run brief
  vdfc_host_ctrl #(.QTR_CYC(4)) vdfc_host_ctrl_i (.*, .bus(lnk.host));
  vdfc_dev_regs vdfc_dev_regs_i (.*, .bus(lnk.device));
  vdfc_assertions vdfc_assertions_i (.*, .scl(lnk.scl));

  initial
  begin
    i_ref_clk = 0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task tick;
    @(posedge i_ref_clk);
    #1;
  endtask : tick

  // One transfer; returns whether it was refused
  task xfer(input logic rd, input logic [7:0] s, input logic [7:0] d, output logic r);
    int n;
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_rd <= rd;
    i_sub <= s;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    #1;
    chk(o_busy | o_refused, 1'b1);
    n = 0;
    while (o_done !== 1'b1 && o_refused !== 1'b1 && n < 4000)
    begin
      tick();
      n++;
    end
    // A hung transfer must not pass as a good write
    if (n == 4000)
    begin
      miscompares++;
      $display("BAD %0t transfer never ended", $time);
    end
    chk(o_busy, 1'b0);
    r = o_refused;
  endtask : xfer

  task wr(input logic [7:0] s, input logic [7:0] d, input logic e);
    logic r;
    xfer(1'b0, s, d, r);
    chk(r, e);
  endtask : wr

  task rd(input logic [7:0] s, input logic [7:0] e);
    logic r;
    xfer(1'b1, s, 8'h00, r);
    chk(o_nack, 1'b0);
    chk(o_rdata, e);
  endtask : rd

  task t_hs;
    wr(8'h06, 8'h94, 1'b0);
    chk($unsigned(o_hsync_begin_llc), 11'h4a0);
    wr(8'h06, 8'h93, 1'b1);
    chk($unsigned(o_hsync_begin_llc), 11'h4a0);
    i_rate_60hz <= 1'b1;
    wr(8'h07, 8'h6b, 1'b0);
    chk($unsigned(o_hsync_end_llc), 11'h358);
    wr(8'h07, 8'h6c, 1'b1);
    wr(8'h06, 8'h94, 1'b1);
    chk(o_hsync_range_err, 1'b0);
  endtask : t_hs

  task t_gain;
    wr(8'h03, 8'h07, 1'b0);
    wr(8'h04, 8'h90, 1'b0);
    wr(8'h05, 8'hff, 1'b0);
    chk(o_gain1_code, 9'h190);
    chk(o_gain2_code, 9'h1ff);
    chk(o_gain_fixed, 1'b1);
    rd(8'h03, 8'h07);
  endtask : t_gain

  task t_aic2;
    wr(8'h03, 8'h40, 1'b1);
    chk(o_white_peak_enable, 1'b1);
    wr(8'h03, 8'hd8, 1'b0);
    rd(8'h03, 8'h58);
    chk(o_clamp_ref_select, 1'b1);
    chk(o_white_peak_enable, 1'b0);
    chk(o_gain_freeze, 1'b1);
    i_decoder_locked <= 1'b1;
    tick();
    chk(o_clamp_ref_select, 1'b0);
  endtask : t_aic2

  task t_susp;
    wr(8'h03, 8'h20, 1'b0);
    i_after_pre_eq <= 1'b1;
    i_line_number <= 10'd23;
    tick();
    chk(o_gain_suspend, 1'b1);
    i_line_number <= 10'd24;
    tick();
    chk(o_gain_suspend, 1'b0);
    wr(8'h08, 8'h40, 1'b0);
    chk(o_field_60hz, 1'b1);
    chk(o_hsync_range_err, 1'b1);
    i_line_number <= 10'd21;
    tick();
    chk(o_gain_suspend, 1'b1);
    i_line_number <= 10'd22;
    tick();
    chk(o_gain_suspend, 1'b0);
    wr(8'h03, 8'h00, 1'b0);
    i_in_eq_serration <= 1'b1;
    tick();
    chk(o_gain_suspend, 1'b1);
  endtask : t_susp

  task t_sync;
    logic [1:0] k;
    for (int j = 0; j < 4; j++)
    begin
      k = j[1:0];
      wr(8'h08, {3'b001, k, 1'b1, k}, 1'b0);
      chk(o_field_60hz, 1'b0);
      chk(o_field_toggle_forced, 1'b1);
      chk(o_horiz_time_constant, k);
      chk(o_htc_reserved, k == 2'h2);
      chk(o_horiz_pll_open, 1'b1);
      chk(o_vertical_noise_mode, k);
    end
    wr(8'h08, 8'h81, 1'b1);
    i_detected_60hz <= 1'b1;
    wr(8'h08, 8'h80, 1'b0);
    chk(o_field_60hz, 1'b1);
    chk(o_horiz_pll_open, 1'b0);
    i_detected_60hz <= 1'b0;
    tick();
    chk(o_field_60hz, 1'b0);
  endtask : t_sync

  task t_luma;
    i_pal_standard <= 1'b1;
    wr(8'h09, 8'h20, 1'b0);
    chk(o_luma_filter, FLT_TRAP);
    chk(o_added_lines, 2'h2);
    wr(8'h09, 8'h60, 1'b0);
    chk(o_luma_filter, FLT_COMB);
    chk(o_added_lines, 2'h0);
    wr(8'h09, 8'h90, 1'b0);
    chk(o_luma_filter, FLT_BYPASS);
    chk(o_wide_notch, 1'b1);
    i_pal_standard <= 1'b0;
    for (int j = 0; j < 16; j++)
    begin
      wr(8'h09, {4'h2, j[3:0]}, 1'b0);
      chk(o_sharpness_filter_select, j[3:0]);
      chk(o_peaking_active, j > 0 && j < 8);
      chk(o_lowpass_active, j > 7);
      chk(o_added_lines, 2'h1);
      chk(o_wide_notch, 1'b0);
    end
    i_yc_mode <= 1'b1;
    wr(8'h09, 8'h00, 1'b0);
    rd(8'h09, 8'h80);
    i_yc_mode <= 1'b0;
  endtask : t_luma

  task t_bright;
    wr(8'h0a, 8'h80, 1'b0);
    chk(o_brightness_offset, 8'h80);
    wr(8'h0a, 8'hff, 1'b0);
    rd(8'h0a, 8'hff);
    rd(8'h0b, 8'h00);
  endtask : t_bright

  task t_mode;
    for (int j = 0; j < 16; j++)
    begin
      i_input_mode <= j[3:0];
      tick();
      chk(o_source_yc, j > 5 && j < 10);
      chk(o_mode_reserved, j > 9);
      chk(o_ch2_static_gain, j == 6 || j == 7);
    end
  endtask : t_mode

  initial
  begin
    i_reset = 1'b1;
    {i_req, i_rd, i_rate_60hz, i_yc_mode} = 4'h0;
    {i_sub, i_wdata} = 16'h0000;
    {i_decoder_locked, i_detected_60hz, i_pal_standard} = 3'h0;
    {i_in_eq_serration, i_after_pre_eq} = 2'h0;
    i_input_mode = 4'h0;
    i_line_number = 10'h000;
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_hs();
    t_gain();
    t_aic2();
    t_susp();
    t_sync();
    t_luma();
    t_bright();
    t_mode();
    end_sim();
  end
endmodule : video_decoder_front_control_regs_bench
`default_nettype wire
